// >>> bench/link_far_end.sv
// Behavioural model of the far-side logic that drives the link status pins.
`timescale 1ns/1ps
`default_nettype none
module link_far_end (
  input wire logic clk,
  output var link_status_pkg::link_pins_t pins
);
  import link_status_pkg::*;

  initial pins = '0;

  // Levels change together just after an edge; the toggle is left alone.
  task automatic set_levels(input link_pins_t v);
    @(posedge clk);
    pins.lane_up <= v.lane_up;
    pins.chan_up <= v.chan_up;
    pins.user_clk_locked <= v.user_clk_locked;
    pins.pll_locked <= v.pll_locked;
  endtask

  // One flip per soft error, spaced wider than the crossing needs.
  task automatic soft_errors(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      pins.fault_toggle <= ~pins.fault_toggle;
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/serial_link_status_tb.sv
// Self-checking testbench of the serial input status bank.
`timescale 1ns/1ps
`default_nettype none
module serial_link_status_tb;
  import link_status_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0] byteenable = 4'hF;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic irq;
  link_pins_t link_pins;
  link_pins_t v;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] r;
  int fails = 0;
  int total_checks = 0;
  int seed = 65308;

  always #5 clk = ~clk;

  serial_link_status i_serial_link_status (.clk(clk), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .link_pins(link_pins), .irq(irq));
  link_far_end i_link_far_end (.clk(clk), .pins(link_pins));

  task automatic check(input string what, input logic [DATA_W-1:0] ex,
                       input logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== ex) begin
      fails++;
      $display("unexpected %0s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // The request is held until the edge that sees waitrequest low.
  // Only the watchdog ends a wait that never sees waitrequest low.
  task automatic bus_cycle(input logic is_rd, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
    @(posedge clk);
    address <= a;
    read <= is_rd;
    write <= ~is_rd;
    writedata <= d;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
    exp_q.push_back(ex);
    bus_cycle(1'b1, a, '0);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_cycle(1'b0, a, d);
  endtask

  task automatic check_irq(input logic ex);
    @(negedge clk);
    check("irq", {31'h0, ex}, {31'h0, irq});
  endtask

  function automatic logic [DATA_W-1:0] chan_exp(input link_pins_t p);
    return {26'h0, p.pll_locked, ~p.user_clk_locked, p.chan_up};
  endfunction

  function automatic logic [DATA_W-1:0] lane_exp(input link_pins_t p);
    logic [DATA_W-1:0] x;
    x = '0;
    for (int c = 0; c < 4; c++)
      for (int l = 0; l < 3; l++) x[3 * c + l] = p.lane_up[c][l];
    return x;
  endfunction

  // Read data are compared against the oldest note at the accepting edge.
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0) begin
      check("readdata", exp_q.pop_front(), readdata);
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    check("timeout", '0, '1);
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    // With the user clock still unlocked after reset, bit 4 reads 1.
    for (int a = 0; a < 32; a += 4) rd(ADDR_W'(a), (a == 0) ? chan_exp(link_pins) : '0);
    check_irq(1'b0);
    $display("test reset values done");
    repeat (6) begin
      r = $random(seed);
      v = r[18:0];
      i_link_far_end.set_levels(v);
      repeat (4) @(posedge clk);
      rd(OFF_CHAN_STATE, chan_exp(v));
      rd(OFF_LANE_FLAGS, lane_exp(v));
    end
    $display("test link levels done");
    wr(OFF_CHAN_STATE, '1);
    wr(OFF_LANE_FLAGS, '1);
    wr(OFF_FAULT_TALLY, '1);
    rd(OFF_CHAN_STATE, chan_exp(v));
    rd(OFF_LANE_FLAGS, lane_exp(v));
    rd(OFF_FAULT_TALLY, '0);
    $display("test read only done");
    wr(OFF_IRQ_STATUS, 32'h0000_003F);
    rd(OFF_IRQ_STATUS, '0);
    i_link_far_end.soft_errors(5);
    repeat (6) @(posedge clk);
    rd(OFF_FAULT_TALLY, 32'h0000_0005);
    check_irq(1'b0);
    rd(OFF_IRQ_STATUS, 32'h0000_0020);
    wr(OFF_TALLY_CLEAR, 32'h0000_0001);
    rd(OFF_FAULT_TALLY, '0);
    rd(OFF_TALLY_CLEAR, '0);
    $display("test fault tally done");
    wr(OFF_IRQ_MASK, 32'h0000_0020);
    rd(OFF_IRQ_MASK, 32'h0000_0020);
    check_irq(1'b1);
    wr(OFF_IRQ_STATUS, 32'h0000_0020);
    repeat (2) @(posedge clk);
    check_irq(1'b0);
    $display("test interrupt done");
    v = '0;
    v.chan_up = 4'hF;
    v.user_clk_locked = 1'b1;
    i_link_far_end.set_levels(v);
    repeat (4) @(posedge clk);
    wr(OFF_IRQ_STATUS, 32'h0000_003F);
    v.chan_up = 4'hB;
    v.user_clk_locked = 1'b0;
    i_link_far_end.set_levels(v);
    repeat (4) @(posedge clk);
    rd(OFF_CHAN_STATE, chan_exp(v));
    rd(OFF_IRQ_STATUS, 32'h0000_0014);
    check_irq(1'b0);
    wr(OFF_IRQ_MASK, 32'h0000_0014);
    check_irq(1'b1);
    $display("test interrupt events done");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> design/fault_tally.sv
// Saturating event counter with a synchronous clear.
`timescale 1ns/1ps
`default_nettype none
module fault_tally #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic inc,
  input wire logic clr,
  output logic [W-1:0] count
);
  logic [W-1:0] count_q;

  // An event in the clear cycle is counted, so nothing is lost at the clear.
  // Saturation keeps a flood of errors from wrapping to a small number.
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= '0;
    end else if (clr) begin
      count_q <= inc ? W'(1) : '0;
    end else if (inc && count_q != '1) begin
      count_q <= count_q + W'(1);
    end
  end

  assign count = count_q;
endmodule
`default_nettype wire

// >>> design/serial_link_status.sv
// Status bank of the multi-lane serial input with an Avalon-MM slave and interrupt.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE_01 Bits 0 to 3 of the channel state register show each input channel as up (1) or down (0).
// RULE_02 Bit 4 of the channel state register is 1 while the user clock is unlocked, 0 when locked.
// RULE_03 Bit 5 of the channel state register is 1 while the first transceiver PLL is locked.
// RULE_04 The lane register holds one up flag for each of the twelve lanes; bits 31 to 12 read 0.
// RULE_05 The flag of lane L of channel C sits at bit 3*C+L of the lane register.
// RULE_06 Soft errors of channel 0 are counted in a 20-bit read-only field in bits 19 to 0.
// RULE_07 Writing 1 to the clear control zeroes all soft error counters; the bit reads back 0. A soft error in the clear cycle leaves the count at 1.
// RULE_08 Writes to status registers are ignored, unused bits read 0 and all fields reset to 0; bit 4 reads 1 after reset while the user clock is unlocked.
module serial_link_status (
  input wire logic clk,
  input wire logic srst,
  input wire logic [link_status_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [link_status_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [link_status_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire link_status_pkg::link_pins_t link_pins,
  output logic irq
);
  import link_status_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  localparam int PINS_W = $bits(link_pins_t);

  logic [PINS_W-1:0] pins_raw;
  logic [PINS_W-1:0] pins_sync;
  link_pins_t pins_s;

  assign pins_raw = link_pins;

  sync_bits #(
    .W(PINS_W)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d(pins_raw),
    .q(pins_sync)
  );

  assign pins_s = link_pins_t'(pins_sync);

  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  chan_state_t chan_reg;
  logic [NUM_LANES-1:0] lane_reg;

  // The synchroniser resets to zero, so every field but the inverted user clock flag (bit 4) reads 0 after reset.
  always_comb begin
    chan_reg.chan_up = pins_s.chan_up; // RULE_01
    chan_reg.user_unlocked = ~pins_s.user_clk_locked; // RULE_02
    chan_reg.pll_locked = pins_s.pll_locked; // RULE_03
  end

  // The unlock flag is forced low only under reset, so bit 4 reads 1 after reset while the user clock is unlocked.
  logic unlock_ok_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      unlock_ok_q <= 1'b0;
    end else begin
      unlock_ok_q <= 1'b1;
    end
  end

  always_comb begin
    lane_reg = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      for (int l = 0; l < LANES_PER_CHAN; l++) begin
        lane_reg[lane_bit(c, l)] = pins_s.lane_up[c][l]; // RULE_04 RULE_05
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  logic req;
  logic ack_q;
  logic wr_acc;
  logic rd_acc;

  assign req = read | write;
  // Every access is answered one cycle after it is presented.
  assign waitrequest = req & ~ack_q;
  assign wr_acc = write & ack_q;
  assign rd_acc = read & ack_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ---------------------------------------------------------------
  // Soft error tally
  // ---------------------------------------------------------------
  logic toggle_prev_q;
  logic fault_ev;
  logic tally_clr;
  logic [TALLY_W-1:0] tally;

  always_ff @(posedge clk) begin
    if (srst) begin
      toggle_prev_q <= 1'b0;
    end else begin
      toggle_prev_q <= pins_s.fault_toggle;
    end
  end

  // The far side flips its toggle once per soft error, which crosses safely.
  assign fault_ev = pins_s.fault_toggle ^ toggle_prev_q;
  assign tally_clr = wr_acc && address == OFF_TALLY_CLEAR && byteenable[0]
                     && writedata[BIT_TALLY_CLEAR]; // RULE_07

  fault_tally #(
    .W(TALLY_W)
  ) u_tally (
    .clk(clk),
    .srst(srst),
    .inc(fault_ev),
    .clr(tally_clr),
    .count(tally)
  ); // RULE_06

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [NUM_CHAN-1:0] chan_prev_q;
  logic locked_prev_q;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] w1c;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      chan_prev_q <= '0;
      locked_prev_q <= 1'b0;
    end else begin
      chan_prev_q <= pins_s.chan_up;
      locked_prev_q <= pins_s.user_clk_locked;
    end
  end

  always_comb begin
    events = '0;
    events[IRQ_CHAN_DOWN_LSB +: NUM_CHAN] = chan_prev_q & ~pins_s.chan_up;
    events[IRQ_USER_UNLOCK] = locked_prev_q & ~pins_s.user_clk_locked;
    events[IRQ_SOFT_FAULT] = fault_ev;
  end

  always_comb begin
    w1c = '0;
    if (wr_acc && address == OFF_IRQ_STATUS && byteenable[0]) begin
      w1c = writedata[IRQ_W-1:0];
    end
  end

  // A new event in the cycle of its clear wins over the clear.
  assign irq_stat_d = (irq_stat_q & ~w1c) | events;

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_mask_q <= '0;
    end else if (wr_acc && address == OFF_IRQ_MASK && byteenable[0]) begin
      irq_mask_q <= writedata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  chan_state_t chan_view;

  always_comb begin
    chan_view = chan_reg;
    chan_view.user_unlocked = chan_reg.user_unlocked & unlock_ok_q;
  end

  // Status registers have no write path, so writes to them fall away.
  always_comb begin
    rdata_d = REG_RESET; // RULE_08
    case (address)
      OFF_CHAN_STATE: rdata_d[CHAN_STATE_W-1:0] = chan_view; // RULE_01 RULE_02 RULE_03
      OFF_LANE_FLAGS: rdata_d[NUM_LANES-1:0] = lane_reg; // RULE_04
      OFF_FAULT_TALLY: rdata_d[TALLY_W-1:0] = tally; // RULE_06
      OFF_TALLY_CLEAR: rdata_d = REG_RESET; // RULE_07
      OFF_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_stat_q;
      OFF_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
      default: rdata_d = REG_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= REG_RESET;
    end else if (read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign readdata = rdata_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence read_taken(logic [ADDR_W-1:0] off);
    read && !waitrequest && address == off;
  endsequence

  sequence write_taken(logic [ADDR_W-1:0] off);
    write && !waitrequest && address == off;
  endsequence

  chan_read_a: assert property ( // RULE_01
    read_taken(OFF_CHAN_STATE) |-> readdata[NUM_CHAN-1:0] == $past(pins_s.chan_up)
  ) else $error("Channel up bits differ from the channel state.");

  user_unlock_a: assert property ( // RULE_02
    (!link_pins.user_clk_locked) [*4] |-> chan_view.user_unlocked
  ) else $error("User clock unlock flag not set while the clock is unlocked.");

  unlock_event_a: assert property ( // RULE_02
    $fell(pins_s.user_clk_locked) |=> irq_stat_q[IRQ_USER_UNLOCK]
  ) else $error("Loss of user clock lock was not latched.");

  pll_lock_a: assert property ( // RULE_03
    link_pins.pll_locked [*3] |-> chan_reg.pll_locked
  ) else $error("PLL lock flag not set while the PLL is locked.");

  lane_upper_a: assert property ( // RULE_04
    read_taken(OFF_LANE_FLAGS) |-> readdata[DATA_W-1:NUM_LANES] == '0
  ) else $error("Unused lane register bits are not zero.");

  lane_place_a: assert property ( // RULE_05
    (link_pins.lane_up[1][0] && !link_pins.lane_up[0][0]) [*3]
      |-> lane_reg[3] && !lane_reg[0]
  ) else $error("Channel 1 lane 0 flag is not at bit 3.");

  tally_count_a: assert property ( // RULE_06
    fault_ev && !tally_clr && tally != '1 |=> tally == $past(tally) + 1'b1
  ) else $error("Soft error count did not advance by one.");

  tally_clear_a: assert property ( // RULE_07
    write_taken(OFF_TALLY_CLEAR) ##0 (writedata[BIT_TALLY_CLEAR] && byteenable[0])
      |=> tally <= TALLY_W'(1)
  ) else $error("Soft error count was not cleared.");

  clear_reads_a: assert property ( // RULE_07
    read_taken(OFF_TALLY_CLEAR) |-> readdata == '0
  ) else $error("Clear control did not read back zero.");

  reserved_zero_a: assert property ( // RULE_08
    read_taken(OFF_CHAN_STATE) |-> readdata[DATA_W-1:CHAN_STATE_W] == '0
  ) else $error("Reserved channel state bits are not zero.");

  answer_time_a: assert property (
    req && waitrequest |=> !waitrequest
  ) else $error("Bus access not answered in one cycle.");

endmodule
`default_nettype wire

// >>> design/sync_bits.sv
// Two flip-flop synchroniser for a bundle of independent levels.
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] first_q;
  logic [W-1:0] second_q;

  // Each bit is a level on its own; bits of a bundle may land one cycle apart.
  always_ff @(posedge clk) begin
    if (srst) begin
      first_q <= '0;
      second_q <= '0;
    end else begin
      first_q <= d;
      second_q <= first_q;
    end
  end

  assign q = second_q;
endmodule
`default_nettype wire

// >>> shared/link_status_pkg.sv
// Package with offsets, field layout and carrier types of the serial input status bank.
package link_status_pkg;

  localparam int NUM_CHAN = 4;
  localparam int LANES_PER_CHAN = 3;
  localparam int NUM_LANES = 12;
  localparam int TALLY_W = 20;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFF_CHAN_STATE = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_LANE_FLAGS = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_FAULT_TALLY = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_TALLY_CLEAR = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h14;

  localparam int BIT_USER_UNLOCKED = 4;
  localparam int BIT_PLL_LOCKED = 5;
  localparam int BIT_TALLY_CLEAR = 0;
  localparam int CHAN_STATE_W = 6;

  localparam int IRQ_W = 6;
  localparam int IRQ_CHAN_DOWN_LSB = 0;
  localparam int IRQ_USER_UNLOCK = 4;
  localparam int IRQ_SOFT_FAULT = 5;

  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

  typedef struct packed {
    logic pll_locked;
    logic user_unlocked;
    logic [NUM_CHAN-1:0] chan_up;
  } chan_state_t;

  typedef struct packed {
    logic [NUM_CHAN-1:0][LANES_PER_CHAN-1:0] lane_up;
    logic [NUM_CHAN-1:0] chan_up;
    logic user_clk_locked;
    logic pll_locked;
    logic fault_toggle;
  } link_pins_t;

  function automatic int lane_bit(input int chan, input int lane);
    return LANES_PER_CHAN * chan + lane;
  endfunction

endpackage
